// >>> design/tx_slip_irq.v
// transmit slip buffer with slip events, interrupt enables and apb access
`timescale 1ns/100ps
`default_nettype none
`include "tx_slip_regs.vh"

module tx_slip_irq
#(
	parameter FRAME_ADDR_WIDTH = 5,
	parameter DATA_WIDTH = 8
)
(
	input wire clock,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [`APB_ADDR_WIDTH-1:0] paddr,
	input wire [`APB_DATA_WIDTH-1:0] pwdata,
	output reg [`APB_DATA_WIDTH-1:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire tx_write,
	input wire [DATA_WIDTH-1:0] tx_write_data,
	input wire tx_read,
	output wire [DATA_WIDTH-1:0] tx_read_data,
	output reg tx_full,
	output reg tx_empty,
	output reg irq
);

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam ADDR_WIDTH = FRAME_ADDR_WIDTH + 1;
	localparam COUNT_WIDTH = ADDR_WIDTH + 1;
	// constants are built at their own width so no arithmetic is cut silently
	localparam [COUNT_WIDTH-1:0] ZERO_COUNT = {COUNT_WIDTH{1'b0}};
	localparam [COUNT_WIDTH-1:0] ONE = {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
	localparam [COUNT_WIDTH-1:0] DEPTH = ONE << ADDR_WIDTH;
	localparam [COUNT_WIDTH-1:0] FRAME = ONE << FRAME_ADDR_WIDTH;
	localparam [ADDR_WIDTH-1:0] ZERO_PTR = {ADDR_WIDTH{1'b0}};
	localparam [ADDR_WIDTH-1:0] ONE_PTR = {{(ADDR_WIDTH-1){1'b0}}, 1'b1};
	localparam [ADDR_WIDTH-1:0] FRAME_PTR = FRAME[ADDR_WIDTH-1:0];
	localparam FIELDS = `TX_FIELD_HI - `TX_FIELD_LO + 1;

	// ****************************************************************
	// address decode helper
	// ****************************************************************
	function hits;
		input [`APB_ADDR_WIDTH-1:0] addr;
		input [`APB_ADDR_WIDTH-1:0] index;
		begin
			hits = (addr == (index << `APB_WORD_SHIFT));
		end
	endfunction

	// registers narrower than the bus read back with zeros above them
	function [`APB_DATA_WIDTH-1:0] widen_reg;
		input [`REG_WIDTH-1:0] value;
		begin
			widen_reg = {{(`APB_DATA_WIDTH-`REG_WIDTH){1'b0}}, value};
		end
	endfunction

	// ****************************************************************
	// state
	// ****************************************************************
	reg [`REG_WIDTH-1:0] slip_buffer_interrupt_enable;
	reg [ADDR_WIDTH-1:0] wr_ptr;
	reg [ADDR_WIDTH-1:0] rd_ptr;
	reg [COUNT_WIDTH-1:0] count;
	reg [ADDR_WIDTH-1:0] next_rd_base;
	reg [ADDR_WIDTH-1:0] next_rd_ptr;
	reg [COUNT_WIDTH-1:0] next_count;
	reg [`APB_DATA_WIDTH-1:0] next_rdata;
	reg next_err;
	wire [FIELDS-1:0] status;
	wire [FIELDS-1:0] events;
	wire [FIELDS-1:0] clears;
	wire [`REG_WIDTH-1:0] status_word;
	wire buf_full;
	wire buf_empty;
	wire overflow;
	wire underflow;
	wire access;
	wire bus_write;
	wire at_status;
	wire at_enable;
	wire at_fill;
	wire capture;
	wire [`APB_DATA_WIDTH-1:0] fill_word;
	wire [ADDR_WIDTH-1:0] next_wr_ptr;
	wire next_full;
	wire next_empty;
	wire tx_overflow_irq_en;
	wire tx_underflow_irq_en;
	wire tx_frame_slip_irq_en;
	wire [FIELDS-1:0] enables;
	wire [FIELDS-1:0] requests;

	// ****************************************************************
	// slip detection
	// ****************************************************************
	assign buf_full = (count == DEPTH);
	assign buf_empty = (count == ZERO_COUNT);

	// a read in the same cycle frees a place, so that write is no slip
	assign overflow = tx_write & buf_full & ~tx_read;
	assign underflow = tx_read & buf_empty;
	// a read on empty with a write in the same cycle still repeats a frame

	// ****************************************************************
	// pointers and fill level
	// ****************************************************************
	always @*
	begin
		next_rd_base = rd_ptr;
		if (overflow)
			next_rd_base = rd_ptr + FRAME_PTR;
		else if (underflow)
			next_rd_base = rd_ptr - FRAME_PTR;
		next_rd_ptr = next_rd_base;
		if (tx_read)
			next_rd_ptr = next_rd_base + ONE_PTR;
	end

	always @*
	begin
		next_count = count;
		if (overflow)
			next_count = next_count - FRAME;
		if (underflow)
			next_count = next_count + FRAME;
		if (tx_write)
			next_count = next_count + ONE;
		if (tx_read)
			next_count = next_count - ONE;
	end

	// a write always lands at the write pointer; after a deletion that cell
	// belonged to the dropped frame, so nothing still queued is overwritten
	assign next_wr_ptr = tx_write ? wr_ptr + ONE_PTR : wr_ptr;

	// level flags come from the next count so they stand in the same
	// cycle as the count that the fill register shows
	assign next_full = (next_count == DEPTH);
	assign next_empty = (next_count == ZERO_COUNT);

	always @(posedge clock)
	begin
		if (reset)
		begin
			wr_ptr <= ZERO_PTR;
			rd_ptr <= ZERO_PTR;
			count <= ZERO_COUNT;
			tx_full <= 1'b0;
			tx_empty <= 1'b1;
		end
		else
		begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			tx_full <= next_full;
			tx_empty <= next_empty;
		end
	end

	// the repeated frame is the one most recently sent, still in the store
	frame_store #(
		.ADDR_WIDTH(ADDR_WIDTH),
		.DATA_WIDTH(DATA_WIDTH)
	) store (
		.clock(clock),
		.reset(reset),
		.write_en(tx_write),
		.write_addr(wr_ptr),
		.write_data(tx_write_data),
		.read_en(tx_read),
		.read_addr(next_rd_base),
		.read_data(tx_read_data)
	);

	// ****************************************************************
	// apb slave, one wait state
	// ****************************************************************
	assign access = psel & penable;
	// the first access cycle, before pready, captures the read data
	assign capture = access & ~pready;
	assign bus_write = access & pready & pwrite;
	assign at_status = hits(paddr, `SLIP_STATUS_IDX);
	assign at_enable = hits(paddr, `SLIP_ENABLE_IDX);
	assign at_fill = hits(paddr, `SLIP_FILL_IDX);
	assign fill_word = {{(`APB_DATA_WIDTH-COUNT_WIDTH){1'b0}}, count};

	always @*
	begin
		next_rdata = `ZERO_WORD;
		next_err = 1'b0;
		if (at_status)
			next_rdata = widen_reg(status_word);
		else if (at_enable)
			next_rdata = widen_reg(slip_buffer_interrupt_enable);
		else if (at_fill)
			next_rdata = fill_word;
		else
			next_err = 1'b1;
	end

	// answer lands at the second access edge; data captured at the first
	always @(posedge clock)
	begin
		if (reset)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `ZERO_WORD;
		end
		else
		begin
			pready <= capture;
			pslverr <= capture & next_err;
			if (capture & ~pwrite)
				prdata <= next_rdata;
		end
	end

	// ****************************************************************
	// enable register
	// ****************************************************************
	// only the three transmit fields are stored; other bits read as zero
	always @(posedge clock)
	begin
		if (reset)
			slip_buffer_interrupt_enable <= `ENABLE_RESET;
		else if (bus_write & at_enable)
		begin
			slip_buffer_interrupt_enable[`TX_FULL_BIT] <= pwdata[`TX_FULL_BIT];
			slip_buffer_interrupt_enable[`TX_EMPTY_BIT] <= pwdata[`TX_EMPTY_BIT];
			slip_buffer_interrupt_enable[`TX_SLIP_BIT] <= pwdata[`TX_SLIP_BIT];
		end
	end

	// enables line up with the status flags: full, empty, slip from the top
	assign tx_overflow_irq_en = slip_buffer_interrupt_enable[`TX_FULL_BIT];
	assign tx_underflow_irq_en = slip_buffer_interrupt_enable[`TX_EMPTY_BIT];
	assign tx_frame_slip_irq_en = slip_buffer_interrupt_enable[`TX_SLIP_BIT];
	assign enables = {tx_overflow_irq_en, tx_underflow_irq_en, tx_frame_slip_irq_en};

	// ****************************************************************
	// status flags
	// ****************************************************************
	assign events[`TX_FULL_BIT-`TX_FIELD_LO] = overflow;
	assign events[`TX_EMPTY_BIT-`TX_FIELD_LO] = underflow;
	assign events[`TX_SLIP_BIT-`TX_FIELD_LO] = overflow | underflow;

	genvar i;
	generate
		for (i = 0; i < FIELDS; i = i + 1)
		begin : flags
			assign clears[i] = bus_write & at_status & pwdata[`TX_FIELD_LO+i];
			// flags latch whatever the enables say
			sticky_flag flag_bit (
				.clock(clock),
				.reset(reset),
				.set(events[i]),
				.clear(clears[i]),
				.flag(status[i])
			);
		end
	endgenerate

	assign status_word = {status, {`TX_FIELD_LO{1'b0}}};

	// ****************************************************************
	// interrupt output
	// ****************************************************************
	// one request per source, so each enable gates only its own status bit
	generate
		for (i = 0; i < FIELDS; i = i + 1)
		begin : sources
			assign requests[i] = status[i] & enables[i];
		end
	endgenerate

	// registered so the pin is glitch free; it follows status one cycle late
	always @(posedge clock)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |requests;
	end

endmodule

`default_nettype wire

// >>> design/tx_slip_regs.vh
// register map and constants for the transmit slip buffer interrupt block
`ifndef TX_SLIP_REGS_VH
`define TX_SLIP_REGS_VH

// ****************************************************************
// register indices (byte address is four times the index)
// ****************************************************************
`define SLIP_STATUS_IDX 16'h0B08
`define SLIP_ENABLE_IDX 16'h0B09
`define SLIP_FILL_IDX 16'h0B0A

// ****************************************************************
// field positions, shared by status and enable registers
// ****************************************************************
`define TX_FULL_BIT 7
`define TX_EMPTY_BIT 6
`define TX_SLIP_BIT 5
`define TX_FIELD_LO 5
`define TX_FIELD_HI 7

// ****************************************************************
// reset values and widths
// ****************************************************************
`define ENABLE_RESET 8'h00
`define STATUS_RESET 8'h00
`define REG_WIDTH 8
`define APB_ADDR_WIDTH 16
`define APB_DATA_WIDTH 32
`define APB_WORD_SHIFT 2
`define ZERO_WORD 32'h00000000

`endif

// >>> design/sticky_flag.v
// one sticky event flag, cleared by writing a one to it
`timescale 1ns/100ps
`default_nettype none

module sticky_flag
(
	input wire clock,
	input wire reset,
	input wire set,
	input wire clear,
	output reg flag
);

	// a set in the same cycle as a clear wins, so no event is lost
	always @(posedge clock)
	begin
		if (reset)
			flag <= 1'b0;
		else if (set)
			flag <= 1'b1;
		else if (clear)
			flag <= 1'b0;
	end

endmodule

`default_nettype wire

// >>> design/frame_store.v
// two-frame byte store of the transmit slip buffer
`timescale 1ns/100ps
`default_nettype none

module frame_store
#(
	parameter ADDR_WIDTH = 6,
	parameter DATA_WIDTH = 8
)
(
	input wire clock,
	input wire reset,
	input wire write_en,
	input wire [ADDR_WIDTH-1:0] write_addr,
	input wire [DATA_WIDTH-1:0] write_data,
	input wire read_en,
	input wire [ADDR_WIDTH-1:0] read_addr,
	output reg [DATA_WIDTH-1:0] read_data
);

	reg [DATA_WIDTH-1:0] cells [0:(1<<ADDR_WIDTH)-1];

	always @(posedge clock)
	begin
		if (write_en)
			cells[write_addr] <= write_data;
	end

	// read data is registered so the top output comes from a flop
	always @(posedge clock)
	begin
		if (reset)
			read_data <= {DATA_WIDTH{1'b0}};
		else if (read_en)
			read_data <= cells[read_addr];
	end

endmodule

`default_nettype wire

// >>> verif/tx_slip_irq_properties.sv
// port checks for the transmit slip interrupt block
`timescale 1ns/100ps
`default_nettype none

module tx_slip_irq_checker
(
	input wire logic clock,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic tx_write,
	input wire logic tx_read,
	input wire logic tx_full,
	input wire logic tx_empty,
	input wire logic irq
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_full_drops_frame: assert property (tx_full && tx_write && !tx_read |=> !tx_full)
		else $error("full buffer kept full");
	a_empty_repeats: assert property (tx_empty && tx_read |=> !tx_empty)
		else $error("empty buffer kept empty");
	a_irq_has_cause: assert property ($rose(irq) |->
		$past(psel && penable && pready && pwrite || tx_write || tx_read, 2))
		else $error("irq rose without cause");
	a_irq_reset_low: assert property ($fell(reset) |-> !irq)
		else $error("irq high after reset");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_one_wait: assert property (psel && penable && !pready |=> pready)
		else $error("wait state count wrong");
	a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
endmodule

bind tx_slip_irq tx_slip_irq_checker chk_u (.clock(clock), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.tx_write(tx_write), .tx_read(tx_read), .tx_full(tx_full), .tx_empty(tx_empty), .irq(irq));

`default_nettype wire

// >>> verif/testbench.sv
// self-checking bench for the transmit slip interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "tx_slip_regs.vh"

module testbench;
	localparam [15:0] stat_a = `SLIP_STATUS_IDX << 2;
	localparam [15:0] en_a = `SLIP_ENABLE_IDX << 2;
	localparam [15:0] fill_a = `SLIP_FILL_IDX << 2;
	logic clock = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, tx_write = 0, tx_read = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h00000000, rdata;
	logic [7:0] tx_write_data = 8'h00;
	logic err;
	wire [31:0] prdata;
	wire [7:0] tx_read_data;
	wire pready, pslverr, tx_full, tx_empty, irq;
	integer failures = 0, n_compared = 0, cycles = 0, i;

	tx_slip_irq dut_u (.clock(clock), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .tx_write(tx_write), .tx_write_data(tx_write_data),
		.tx_read(tx_read), .tx_read_data(tx_read_data), .tx_full(tx_full),
		.tx_empty(tx_empty), .irq(irq));

	initial forever #10 clock = ~clock;

	// the whole run takes about 270 cycles
	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 5000)
		begin
			failures = failures + 1;
			give_verdict;
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_compared = n_compared + 1;
			if (seen !== exp)
			begin
				failures = failures + 1;
				$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		begin
			@(posedge clock);
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clock);
			penable <= 1;
			@(posedge clock);
			while (pready !== 1'h1)
				@(posedge clock);
			rdata = prdata;
			err = pslverr;
			psel <= 0;
			penable <= 0;
		end
	endtask

	// #1 lets the edge's register updates land before the caller looks
	task op(input logic w, input logic r, input logic [7:0] d);
		begin
			@(posedge clock);
			tx_write <= w;
			tx_read <= r;
			tx_write_data <= d;
			@(posedge clock);
			tx_write <= 0;
			tx_read <= 0;
			#1;
		end
	endtask

	task irq_after(input logic [31:0] en, input logic exp);
		begin
			apb(1, en_a, en);
			repeat (2) @(posedge clock);
			check(irq, exp);
		end
	endtask

	task give_verdict;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask

	initial
	begin
		repeat (3) @(posedge clock);
		reset <= 0;
		apb(0, en_a, 0);
		check(rdata, 32'h00);
		apb(0, stat_a, 0);
		check(rdata, 32'h00);
		apb(1, en_a, 32'hFFFFFFFF);
		apb(0, en_a, 0);
		check(rdata, 32'hE0);
		apb(1, en_a, 0);
		for (i = 0; i < 64; i = i + 1)
			op(1, 0, i[7:0]);
		check(tx_full, 1'h1);
		op(1, 0, 8'h40);
		apb(0, stat_a, 0);
		check(rdata, 32'hA0);
		check(irq, 1'h0);
		apb(0, fill_a, 0);
		check(rdata, 32'h21);
		op(0, 1, 8'h00);
		check(tx_read_data, 8'h20);
		irq_after(32'h80, 1'h1);
		irq_after(32'h20, 1'h1);
		apb(1, stat_a, 32'hA0);
		apb(0, stat_a, 0);
		check(rdata, 32'h00);
		check(irq, 1'h0);
		for (i = 0; i < 32; i = i + 1)
			op(0, 1, 8'h00);
		check(tx_empty, 1'h1);
		op(0, 1, 8'h00);
		check(tx_read_data, 8'h21);
		apb(0, stat_a, 0);
		check(rdata, 32'h60);
		apb(0, fill_a, 0);
		check(rdata, 32'h1F);
		check(irq, 1'h1);
		irq_after(32'h40, 1'h1);
		irq_after(32'h80, 1'h0);
		apb(0, 16'h0004, 0);
		check(err, 1'h1);
		check(rdata, 32'h00);
		give_verdict;
	end
endmodule

`default_nettype wire
